//--- inc/fault_flag_aggregator_map.svh
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: Included by bare name from the aggregator design file and the testbench.
// Notes: Definitions only.
`ifndef FAULT_FLAG_AGGREGATOR_MAP_SVH
`define FAULT_FLAG_AGGREGATOR_MAP_SVH

`define ADDR_GLOBAL 8'h50
`define ADDR_INT1 8'h51
`define ADDR_INT2 8'h52
`define ADDR_INT3 8'h53
`define ADDR_CORE_STATUS 8'h55

`define GLB_ANY 7
`define GLB_INT1 6
`define GLB_INT2 5
`define GLB_INT3 4
`define GLB_BUS_GROUP 3

`define I1_WATCHDOG 7
`define I1_BUS_WAKE 6
`define I1_LOCAL_WAKE 5
`define I1_WAKE_ERROR 4
`define I1_FRAME_OVERFLOW 3
`define I1_BUS_SILENT 2
`define I1_BUS_TIMEOUT 1
`define I1_STUCK_DOM 0

`define I2_FORCED_SLEEP 7
`define I2_POWER_UP 6
`define I2_MAIN_LOW 4
`define I2_IO_LOW 3
`define I2_CORE_LOW 2
`define I2_OVERHEAT 1
`define I2_OVERHEAT_WARN 0

`define I3_SERIAL_ERR 7
`define I3_FAILSAFE 5
`define I3_CRC_ERR 0

`define CS_TXD_TIMEOUT 0
`define CS_FAILSAFE 1
`define CS_CRC_DONE 2

`define INT1_RST 8'h00
`define INT2_RST 8'h40
`define INT3_RST 8'h00
`define INT1_MASK 8'hFF
`define INT2_MASK 8'hDF
`define INT3_MASK 8'hA1

`define FRAME_BITS 5'h10
`define ADDR_BITS 5'h08
`define WRITE_BIT 7

`define CRC_POLY 8'h07
`define CRC_INIT 8'hFF

`define CLK_PERIOD_NS 10
`define TXD_DOM_TIME_NS 1000000

`endif

//--- inc/fault_flag_pkg.sv
// Purpose: Shared types of the fault flag aggregator.
// Assumes: Nothing is imported; users write the package name.
// Notes: Numbers live in the map header.
package fault_flag_pkg;

  typedef logic [7:0] byte_t;

  typedef enum logic [1:0] {
    CRC_RUN,
    CRC_CHECK,
    CRC_DONE
  } crc_state_t;

endpackage : fault_flag_pkg

//--- rtl/fault_flag_aggregator.sv
// Purpose: Sticky fault flags, global summary and serial register port.
// Assumes: Serial clock at most one eighth of core_clk; mode 0 framing.
// Notes: Summary bits are pure logic over the flags, never stored.
//
// Functional notes
// - Every selected serial access shifts out the global summary first.
// - Summary bit 7 is the OR of every flag and the bus group, read-only, resets one.
// - Summary bits 6 and 5 are ORs of the first and second flag bytes.
// - Bits 4 and 3 OR third byte and bus-fault group; 2..0 reserved.
// - Watchdog flag sets on every watchdog error event.
// - Bus wake flag latches on bus wake-up; resets zero.
// - Wake error sets when wake timer expires and mode is sleep.
// - Frame error overflow flag latches on counter overflow.
// - Stuck dominant flag latches when bus held dominant.
// - Forced sleep flag sets only for listed sleep entry causes.
// - Main, I/O and core supply undervoltage latch separate flags.
// - Overheat disables transmitter, enters fail-safe, latches flags.
// - Serial error flag sets on serial status error, write one clears.
// - Transmit input held dominant too long is timed out.
// - Trim storage is checked by CRC after reset.
`timescale 1ns/100ps
`default_nettype none
`include "fault_flag_aggregator_map.svh"

module fault_flag_aggregator #(
  parameter int TXD_DOM_CYCLES = `TXD_DOM_TIME_NS / `CLK_PERIOD_NS,
  parameter int TRIM_WORDS = 8
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic chip_select_low,
  input wire logic sclk,
  input wire logic sdi,
  output logic sdo_data,
  output logic sdo_oe,
  input wire logic txd,
  output logic tx_enable,
  output logic thermal_failsafe,
  input wire logic bus_wake_det,
  input wire logic local_wake_det,
  input wire logic stuck_dom_det,
  input wire logic main_supply_low,
  input wire logic io_supply_low,
  input wire logic core_supply_low,
  input wire logic overheat,
  input wire logic overheat_warn,
  input wire logic watchdog_event,
  input wire logic wake_timer_expired,
  input wire logic mode_is_sleep,
  input wire logic frame_overflow,
  input wire logic bus_silent,
  input wire logic bus_timeout,
  input wire logic sleep_entry,
  input wire logic io_low_timeout,
  input wire logic bus_fault_pending,
  output logic [7:0] trim_index,
  input wire logic [7:0] trim_word
);

  localparam int TXD_W = $clog2(TXD_DOM_CYCLES + 1);

  if (TXD_DOM_CYCLES < 1) begin : g_bad_txd
    $error("TXD_DOM_CYCLES must be at least one");
  end
  if (TRIM_WORDS < 1 || TRIM_WORDS > 255) begin : g_bad_trim
    $error("TRIM_WORDS must lie between 1 and 255");
  end

  // Pin inputs.
  logic [11:0] pin_raw;
  logic [11:0] pin_s;
  logic cs_n_s;
  logic sclk_s;
  logic sdi_s;
  logic txd_s;
  logic bus_wake_s;
  logic local_wake_s;
  logic stuck_dom_s;
  logic main_low_s;
  logic io_low_s;
  logic core_low_s;
  logic overheat_s;
  logic warn_s;

  assign pin_raw = {chip_select_low, sclk, sdi, txd, bus_wake_det,
                    local_wake_det, stuck_dom_det, main_supply_low,
                    io_supply_low, core_supply_low, overheat,
                    overheat_warn};

  // Select and transmit idle high, so they leave reset inactive.
  flag_sync #(
    .WIDTH(12),
    .RST_VAL(12'h900)
  ) u_pin_sync (
    .core_clk(core_clk),
    .reset(reset),
    .pin_in(pin_raw),
    .level_out(pin_s)
  );

  assign {cs_n_s, sclk_s, sdi_s, txd_s, bus_wake_s, local_wake_s,
          stuck_dom_s, main_low_s, io_low_s, core_low_s, overheat_s,
          warn_s} = pin_s;

  // Flag registers.
  logic [7:0] int1_ff;
  logic [7:0] int2_ff;
  logic [7:0] int3_ff;
  logic [7:0] int1_set;
  logic [7:0] int2_set;
  logic [7:0] int3_set;
  logic [7:0] int1_clr;
  logic [7:0] int2_clr;
  logic [7:0] int3_clr;
  logic [7:0] global_summary;
  logic [7:0] core_status;

  // Serial port state.
  logic sclk_prev_ff;
  logic cs_prev_ff;
  logic [4:0] bit_cnt_ff;
  logic [7:0] rx_ff;
  logic [7:0] addr_ff;
  logic [7:0] tx_ff;
  logic [7:0] nxt_tx;
  logic sdo_ff;
  logic sdo_oe_ff;
  logic wr_strobe_ff;
  logic [7:0] wr_addr_ff;
  logic [7:0] wr_data_ff;
  logic serial_err_ff;
  logic sclk_rise;
  logic sclk_fall;
  logic frame_start;
  logic frame_end;

  // Transmit, thermal and trim check state.
  logic [TXD_W-1:0] txd_cnt_ff;
  logic txd_timeout_ff;
  logic failsafe_ff;
  logic tx_enable_ff;
  fault_flag_pkg::crc_state_t crc_state_ff;
  logic [7:0] crc_ff;
  logic [7:0] trim_index_ff;
  logic crc_err_ff;

  function automatic logic [7:0] crc8_step(input logic [7:0] crc,
                                           input logic [7:0] data);
    logic [7:0] acc;
    acc = crc ^ data;
    for (int i = 0; i < 8; i++) begin
      acc = acc[7] ? ((acc << 1) ^ `CRC_POLY) : (acc << 1);
    end
    return acc;
  endfunction : crc8_step

  // Unmapped addresses read as zero.
  function automatic logic [7:0] reg_read(input logic [7:0] addr);
    if (addr == `ADDR_GLOBAL) begin
      return global_summary;
    end else if (addr == `ADDR_INT1) begin
      return int1_ff;
    end else if (addr == `ADDR_INT2) begin
      return int2_ff;
    end else if (addr == `ADDR_INT3) begin
      return int3_ff;
    end else if (addr == `ADDR_CORE_STATUS) begin
      return core_status;
    end else begin
      return 8'h00;
    end
  endfunction : reg_read

  function automatic logic [7:0] clr_for(input logic [7:0] addr);
    return (wr_strobe_ff && wr_addr_ff == addr) ? wr_data_ff : 8'h00;
  endfunction : clr_for

  // Event sources.
  always_comb begin
    int1_set = 8'h00;
    int1_set[`I1_WATCHDOG] = watchdog_event;
    int1_set[`I1_BUS_WAKE] = bus_wake_s;
    int1_set[`I1_LOCAL_WAKE] = local_wake_s;
    int1_set[`I1_WAKE_ERROR] = wake_timer_expired & mode_is_sleep;
    int1_set[`I1_FRAME_OVERFLOW] = frame_overflow;
    int1_set[`I1_BUS_SILENT] = bus_silent;
    int1_set[`I1_BUS_TIMEOUT] = bus_timeout;
    int1_set[`I1_STUCK_DOM] = stuck_dom_s;
  end

  always_comb begin
    int2_set = 8'h00;
    int2_set[`I2_FORCED_SLEEP] = sleep_entry &
        (int1_set[`I1_WAKE_ERROR] | io_low_timeout |
         (io_low_s & overheat_s));
    int2_set[`I2_MAIN_LOW] = main_low_s;
    int2_set[`I2_IO_LOW] = io_low_s;
    int2_set[`I2_CORE_LOW] = core_low_s;
    int2_set[`I2_OVERHEAT] = overheat_s;
    int2_set[`I2_OVERHEAT_WARN] = warn_s;
  end

  always_comb begin
    int3_set = 8'h00;
    int3_set[`I3_SERIAL_ERR] = serial_err_ff;
    int3_set[`I3_FAILSAFE] = overheat_s & ~failsafe_ff;
    int3_set[`I3_CRC_ERR] = crc_err_ff;
  end

  // A process, so the write strobe read inside the function wakes it.
  always_comb begin
    int1_clr = clr_for(`ADDR_INT1);
    int2_clr = clr_for(`ADDR_INT2);
    int3_clr = clr_for(`ADDR_INT3);
  end

  // The set term is ORed after the clear, so a coincident event survives.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      int1_ff <= `INT1_RST;
      int2_ff <= `INT2_RST;
      int3_ff <= `INT3_RST;
    end else begin
      int1_ff <= ((int1_ff & ~int1_clr) | int1_set) & `INT1_MASK;
      int2_ff <= ((int2_ff & ~int2_clr) | int2_set) & `INT2_MASK;
      int3_ff <= ((int3_ff & ~int3_clr) | int3_set) & `INT3_MASK;
    end
  end

  always_comb begin
    global_summary = 8'h00;
    global_summary[`GLB_ANY] = |{int1_ff, int2_ff, int3_ff,
                                 bus_fault_pending};
    global_summary[`GLB_INT1] = |int1_ff;
    global_summary[`GLB_INT2] = |int2_ff;
    global_summary[`GLB_INT3] = |int3_ff;
    global_summary[`GLB_BUS_GROUP] = bus_fault_pending;
  end

  always_comb begin
    core_status = 8'h00;
    core_status[`CS_TXD_TIMEOUT] = txd_timeout_ff;
    core_status[`CS_FAILSAFE] = failsafe_ff;
    core_status[`CS_CRC_DONE] = (crc_state_ff == fault_flag_pkg::CRC_DONE);
  end

  // Serial port.
  assign sclk_rise = sclk_s & ~sclk_prev_ff;
  assign sclk_fall = ~sclk_s & sclk_prev_ff;
  assign frame_start = cs_prev_ff & ~cs_n_s;
  assign frame_end = ~cs_prev_ff & cs_n_s;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sclk_prev_ff <= 1'b0;
      cs_prev_ff <= 1'b1;
    end else begin
      sclk_prev_ff <= sclk_s;
      cs_prev_ff <= cs_n_s;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      bit_cnt_ff <= 5'h00;
      rx_ff <= 8'h00;
      addr_ff <= 8'h00;
    end else if (frame_start) begin
      bit_cnt_ff <= 5'h00;
    end else if (!cs_n_s && sclk_rise) begin
      rx_ff <= {rx_ff[6:0], sdi_s};
      if (bit_cnt_ff != 5'h1F) begin
        bit_cnt_ff <= bit_cnt_ff + 5'h01;
      end
      if (bit_cnt_ff == `ADDR_BITS - 5'h01) begin
        addr_ff <= {rx_ff[6:0], sdi_s};
      end
    end
  end

  // The summary goes out on the first byte; the read data on the second.
  always_comb begin
    nxt_tx = tx_ff;
    if (frame_start) begin
      nxt_tx = global_summary;
    end else if (!cs_n_s && sclk_fall) begin
      if (bit_cnt_ff == `ADDR_BITS) begin
        nxt_tx = reg_read({1'b0, addr_ff[6:0]});
      end else begin
        nxt_tx = {tx_ff[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      tx_ff <= 8'h00;
      sdo_ff <= 1'b0;
      sdo_oe_ff <= 1'b0;
    end else begin
      tx_ff <= nxt_tx;
      sdo_ff <= nxt_tx[7];
      sdo_oe_ff <= ~cs_n_s;
    end
  end

  // A frame of any length other than sixteen bits is a serial error.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wr_strobe_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      wr_data_ff <= 8'h00;
      serial_err_ff <= 1'b0;
    end else begin
      wr_strobe_ff <= frame_end && bit_cnt_ff == `FRAME_BITS &&
                      addr_ff[`WRITE_BIT];
      wr_addr_ff <= {1'b0, addr_ff[6:0]};
      wr_data_ff <= rx_ff;
      serial_err_ff <= frame_end && bit_cnt_ff != `FRAME_BITS;
    end
  end

  // Transmit dominant timeout and thermal fail-safe.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      txd_cnt_ff <= '0;
      txd_timeout_ff <= 1'b0;
    end else if (txd_s) begin
      txd_cnt_ff <= '0;
      txd_timeout_ff <= 1'b0;
    end else if (txd_cnt_ff != TXD_W'(TXD_DOM_CYCLES)) begin
      txd_cnt_ff <= txd_cnt_ff + TXD_W'(1);
    end else begin
      txd_timeout_ff <= 1'b1;
    end
  end

  // Fail-safe holds for as long as the die stays hot.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      failsafe_ff <= 1'b0;
      tx_enable_ff <= 1'b0;
    end else begin
      failsafe_ff <= overheat_s;
      tx_enable_ff <= ~overheat_s & ~txd_timeout_ff;
    end
  end

  // Trim check walks the words, then compares with the stored CRC word.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      crc_state_ff <= fault_flag_pkg::CRC_RUN;
      crc_ff <= `CRC_INIT;
      trim_index_ff <= 8'h00;
      crc_err_ff <= 1'b0;
    end else begin
      crc_err_ff <= 1'b0;
      case (crc_state_ff)
        fault_flag_pkg::CRC_RUN: begin
          crc_ff <= crc8_step(crc_ff, trim_word);
          trim_index_ff <= trim_index_ff + 8'h01;
          if (trim_index_ff == 8'(TRIM_WORDS - 1)) begin
            crc_state_ff <= fault_flag_pkg::CRC_CHECK;
          end
        end
        fault_flag_pkg::CRC_CHECK: begin
          crc_err_ff <= (trim_word != crc_ff);
          crc_state_ff <= fault_flag_pkg::CRC_DONE;
        end
        default: begin
          crc_state_ff <= fault_flag_pkg::CRC_DONE;
        end
      endcase
    end
  end

  assign sdo_data = sdo_ff;
  assign sdo_oe = sdo_oe_ff;
  assign tx_enable = tx_enable_ff;
  assign thermal_failsafe = failsafe_ff;
  assign trim_index = trim_index_ff;

endmodule : fault_flag_aggregator

`default_nettype wire

//--- rtl/flag_sync.sv
// Purpose: Three-stage synchroniser with agreement filter for pin inputs.
// Assumes: Pins are asynchronous to core_clk.
// Notes: The output follows only when stages two and three agree.
`timescale 1ns/100ps
`default_nettype none

module flag_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] mid_ff;
  logic [WIDTH-1:0] late_ff;
  logic [WIDTH-1:0] level_ff;
  logic [WIDTH-1:0] agree;

  if (WIDTH < 1) begin : g_bad_width
    $error("flag_sync needs at least one bit");
  end

  // The first stage feeds the second stage and nothing else.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      meta_ff <= RST_VAL;
      mid_ff <= RST_VAL;
      late_ff <= RST_VAL;
    end else begin
      meta_ff <= pin_in;
      mid_ff <= meta_ff;
      late_ff <= mid_ff;
    end
  end

  assign agree = ~(mid_ff ^ late_ff);

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      level_ff <= RST_VAL;
    end else begin
      level_ff <= (level_ff & ~agree) | (mid_ff & agree);
    end
  end

  assign level_out = level_ff;

endmodule : flag_sync

`default_nettype wire

//--- sim/fault_flag_aggregator_sva.sv
// Purpose: Port-level checks of the fault flag aggregator.
// Assumes: Serial clock phases last at least four core cycles.
// Notes: Bound into every instance of the design.
`timescale 1ns/100ps
`default_nettype none

module fault_flag_aggregator_sva #(
  parameter int TXD_DOM_CYCLES = 100000,
  parameter int TRIM_WORDS = 8
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic chip_select_low,
  input wire logic sdo_oe,
  input wire logic txd,
  input wire logic tx_enable,
  input wire logic thermal_failsafe,
  input wire logic overheat,
  input wire logic [7:0] trim_index
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  int unsigned dom_cnt_ff;
  // Saturating, so a long stuck line cannot wrap back into range.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      dom_cnt_ff <= 0;
    end else if (txd) begin
      dom_cnt_ff <= 0;
    end else if (dom_cnt_ff < 32'h0000FFFF) begin
      dom_cnt_ff <= dom_cnt_ff + 1;
    end
  end
  sequence s_hot;
    overheat [*7];
  endsequence
  sequence s_cool;
    !overheat [*8];
  endsequence
  property p_oe_on;
    $fell(chip_select_low) |-> ##[2:6] sdo_oe;
  endproperty
  property p_oe_off;
    chip_select_low [*8] |-> !sdo_oe;
  endproperty
  property p_oe_cause;
    $rose(sdo_oe) |-> !$past(chip_select_low, 3);
  endproperty
  property p_fs_on;
    s_hot |-> thermal_failsafe;
  endproperty
  property p_fs_off;
    s_cool |-> !thermal_failsafe;
  endproperty
  property p_tx_hot;
    s_hot |-> !tx_enable;
  endproperty
  property p_txd_to;
    dom_cnt_ff > TXD_DOM_CYCLES + 8 |-> !tx_enable;
  endproperty
  property p_trim_cap;
    trim_index <= TRIM_WORDS;
  endproperty
  property p_trim_go;
    $fell(reset) |-> ##[1:20] trim_index != 8'h00;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("sdo not enabled");
  a_oe_off: assert property (p_oe_off) else $error("sdo stays on");
  a_oe_cause: assert property (p_oe_cause) else $error("sdo on unasked");
  a_fs_on: assert property (p_fs_on) else $error("no fail-safe");
  a_fs_off: assert property (p_fs_off) else $error("fail-safe stuck");
  a_tx_hot: assert property (p_tx_hot) else $error("tx on while hot");
  a_txd_to: assert property (p_txd_to) else $error("no txd timeout");
  a_trim_cap: assert property (p_trim_cap) else $error("trim overrun");
  a_trim_go: assert property (p_trim_go) else $error("trim idle");
endmodule : fault_flag_aggregator_sva

bind fault_flag_aggregator fault_flag_aggregator_sva #(
  .TXD_DOM_CYCLES(TXD_DOM_CYCLES),
  .TRIM_WORDS(TRIM_WORDS)
) fault_flag_aggregator_sva_inst (.core_clk, .reset, .chip_select_low,
  .sdo_oe, .txd, .tx_enable, .thermal_failsafe, .overheat, .trim_index);

`default_nettype wire

//--- sim/host_model.sv
// Purpose: Host processor driving the serial register port.
// Assumes: Mode 0, MSB first, each clock phase eight core cycles.
// Notes: Serial clock stands low and data in rests high between frames.
`timescale 1ns/100ps
`default_nettype none

module host_model (
  input wire logic core_clk,
  input wire logic sdo_line,
  output logic chip_select_low,
  output logic sclk,
  output logic sdi
);
  initial begin
    chip_select_low = 1'b1;
    sclk = 1'b0;
    sdi = 1'b1;
  end
  task automatic xfer(input int nbits, input logic [15:0] tx,
                      output logic [15:0] rx);
    rx = 16'hFFFF;
    @(negedge core_clk);
    chip_select_low = 1'b0;
    repeat (8) @(negedge core_clk);
    for (int i = 0; i < nbits; i++) begin
      sdi = tx[15-i];
      repeat (8) @(negedge core_clk);
      sclk = 1'b1;
      rx[15-i] = sdo_line;
      repeat (8) @(negedge core_clk);
      sclk = 1'b0;
    end
    repeat (8) @(negedge core_clk);
    sdi = 1'b1;
    chip_select_low = 1'b1;
    // Idle gap covers the write strobe and the frame spacing.
    repeat (12) @(negedge core_clk);
  endtask : xfer
endmodule : host_model

`default_nettype wire

//--- sim/test_fault_flag_aggregator.sv
// Purpose: Self-checking bench of the fault flag aggregator.
// Assumes: Txd timeout shortened to 20 cycles.
// Notes: All register traffic goes through the serial port.
`timescale 1ns/100ps
`default_nettype none
`include "fault_flag_aggregator_map.svh"

module test_fault_flag_aggregator;
  logic core_clk, reset, chip_select_low, sclk, sdi, sdo_data, sdo_oe;
  logic txd, tx_enable, thermal_failsafe, sdo_line, sdo_last, crc_bad;
  logic watchdog_event, bus_wake_det, local_wake_det, wake_timer_expired;
  logic mode_is_sleep, frame_overflow, bus_silent, bus_timeout;
  logic stuck_dom_det, sleep_entry, io_low_timeout, main_supply_low;
  logic io_supply_low, core_supply_low, overheat, overheat_warn;
  logic bus_fault_pending;
  logic [7:0] trim_index, trim_word, crc_ref, s;
  logic [15:0] r;
  logic [16:0] ev;
  int n_errors = 0;
  int n_tests = 0;
  typedef struct {logic [16:0] m; logic [7:0] e1, e2, e3;} case_t;
  case_t tbl [14] = '{'{17'h00001, 8'h80, 8'h00, 8'h00},
    '{17'h00002, 8'h40, 8'h00, 8'h00}, '{17'h00004, 8'h20, 8'h00, 8'h00},
    '{17'h00018, 8'h10, 8'h00, 8'h00}, '{17'h00008, 8'h00, 8'h00, 8'h00},
    '{17'h00020, 8'h08, 8'h00, 8'h00}, '{17'h000C0, 8'h06, 8'h00, 8'h00},
    '{17'h00100, 8'h01, 8'h00, 8'h00}, '{17'h00200, 8'h00, 8'h00, 8'h00},
    '{17'h00600, 8'h00, 8'h80, 8'h00}, '{17'h03800, 8'h00, 8'h1C, 8'h00},
    '{17'h05200, 8'h00, 8'h8A, 8'h20}, '{17'h08000, 8'h00, 8'h01, 8'h00},
    '{17'h10000, 8'h00, 8'h00, 8'h00}};
  assign {bus_fault_pending, overheat_warn, overheat, core_supply_low,
    io_supply_low, main_supply_low, io_low_timeout, sleep_entry,
    stuck_dom_det, bus_timeout, bus_silent, frame_overflow, mode_is_sleep,
    wake_timer_expired, local_wake_det, bus_wake_det, watchdog_event} = ev;
  function automatic logic [7:0] trim_val(input logic [7:0] i);
    return 8'h3C ^ (i * 8'h11);
  endfunction : trim_val
  assign trim_word = (trim_index < 8'h08) ? trim_val(trim_index)
                     : crc_ref ^ {7'h00, crc_bad};
  // A released output line shows the inverse of its last driven level.
  always @(posedge core_clk) if (sdo_oe) sdo_last <= sdo_data;
  assign sdo_line = sdo_oe ? sdo_data : ~sdo_last;
  fault_flag_aggregator #(.TXD_DOM_CYCLES(20), .TRIM_WORDS(8))
    fault_flag_aggregator_inst (.core_clk, .reset, .chip_select_low, .sclk,
    .sdi, .sdo_data, .sdo_oe, .txd, .tx_enable, .thermal_failsafe,
    .bus_wake_det, .local_wake_det, .stuck_dom_det, .main_supply_low,
    .io_supply_low, .core_supply_low, .overheat, .overheat_warn,
    .watchdog_event, .wake_timer_expired, .mode_is_sleep, .frame_overflow,
    .bus_silent, .bus_timeout, .sleep_entry, .io_low_timeout,
    .bus_fault_pending, .trim_index, .trim_word);
  host_model host_model_inst (.core_clk, .sdo_line, .chip_select_low, .sclk,
    .sdi);
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic give_verdict();
    $display("Comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic rd(input logic [7:0] a, input logic [7:0] es,
                    input logic [7:0] ed);
    host_model_inst.xfer(16, {1'b0, a[6:0], 8'h00}, r);
    check(r[15:8], es);
    check(r[7:0], ed);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_model_inst.xfer(16, {1'b1, a[6:0], d}, r);
  endtask : wr
  task automatic do_reset();
    int i;
    reset = 1'b1;
    repeat (16) @(negedge core_clk);
    reset = 1'b0;
    i = 0;
    while (tx_enable !== 1'b1 && i < 50) begin
      @(negedge core_clk);
      i++;
    end
    if (i == 50) begin
      n_errors++;
      give_verdict();
    end
    repeat (20) @(negedge core_clk);
  endtask : do_reset
  initial begin
    #1_000_000;
    n_errors++;
    give_verdict();
  end
  initial begin
    ev = 17'h00000;
    txd = 1'b1;
    crc_bad = 1'b0;
    reset = 1'b1;
    crc_ref = `CRC_INIT;
    for (int w = 0; w < 8; w++) begin
      crc_ref = crc_ref ^ trim_val(w[7:0]);
      for (int b = 0; b < 8; b++)
        crc_ref = crc_ref[7] ? ((crc_ref << 1) ^ `CRC_POLY) : (crc_ref << 1);
    end
    do_reset();
    rd(`ADDR_INT1, 8'hA0, 8'h00);
    rd(`ADDR_INT2, 8'hA0, 8'h40);
    rd(`ADDR_INT3, 8'hA0, 8'h00);
    rd(`ADDR_CORE_STATUS, 8'hA0, 8'h04);
    wr(`ADDR_INT2, 8'h40);
    rd(`ADDR_GLOBAL, 8'h00, 8'h00);
    wr(`ADDR_GLOBAL, 8'hFF);
    rd(`ADDR_GLOBAL, 8'h00, 8'h00);
    rd(8'h60, 8'h00, 8'h00);
    foreach (tbl[k]) begin
      ev = tbl[k].m;
      repeat (8) @(negedge core_clk);
      ev = tbl[k].m & 17'h10000;
      repeat (8) @(negedge core_clk);
      s = {|{tbl[k].e1, tbl[k].e2, tbl[k].e3, tbl[k].m[16]}, |tbl[k].e1,
           |tbl[k].e2, |tbl[k].e3, tbl[k].m[16], 3'b000};
      rd(`ADDR_INT1, s, tbl[k].e1);
      rd(`ADDR_INT2, s, tbl[k].e2);
      rd(`ADDR_INT3, s, tbl[k].e3);
      ev = 17'h00000;
      wr(`ADDR_INT1, 8'hFF);
      wr(`ADDR_INT2, 8'hFF);
      wr(`ADDR_INT3, 8'hFF);
    end
    rd(`ADDR_GLOBAL, 8'h00, 8'h00);
    ev = 17'h00041;
    repeat (8) @(negedge core_clk);
    ev = 17'h00000;
    wr(`ADDR_INT1, 8'h00);
    rd(`ADDR_INT1, 8'hC0, 8'h84);
    wr(`ADDR_INT1, 8'h04);
    rd(`ADDR_INT1, 8'hC0, 8'h80);
    ev = 17'h00800;
    repeat (8) @(negedge core_clk);
    wr(`ADDR_INT2, 8'hFF);
    rd(`ADDR_INT2, 8'hE0, 8'h10);
    ev = 17'h00000;
    repeat (8) @(negedge core_clk);
    wr(`ADDR_INT1, 8'hFF);
    wr(`ADDR_INT2, 8'hFF);
    rd(`ADDR_GLOBAL, 8'h00, 8'h00);
    host_model_inst.xfer(8, 16'h5100, r);
    rd(`ADDR_INT3, 8'h90, 8'h80);
    wr(`ADDR_INT3, 8'h80);
    rd(`ADDR_INT3, 8'h00, 8'h00);
    txd = 1'b0;
    repeat (40) @(negedge core_clk);
    check({7'h00, tx_enable}, 8'h00);
    rd(`ADDR_CORE_STATUS, 8'h00, 8'h05);
    txd = 1'b1;
    repeat (10) @(negedge core_clk);
    crc_bad = 1'b1;
    do_reset();
    rd(`ADDR_INT3, 8'hB0, 8'h01);
    give_verdict();
  end
endmodule : test_fault_flag_aggregator

`default_nettype wire
